//--- hw/cpf_pkg.sv
// Functional notes
// - Overvoltage: input off, battery on, flag, alert
// - Overvoltage drops power valid; hysteretic release
// - Rail short: input off 200us, on 5ms
// - After ten tries: input off 2s, battery powers
// - Persisting short sets status, flag, alert
// - Lockout end clears status, restarts tries
// - Battery path opens below depletion threshold
// - Battery-only switch follows depletion threshold
// - Depletion status, flag and unmasked alert
// - Battery lockout level gates power without input
// - Overcurrent opens switch, retries after 250ms
// - Repeated trips in 2s lock switch off
// - Supplement trip needs input toggle to recover
// - Phase timers start; expiry disables charging
// - Precharge timer is quarter of maximum
// - Timer expiry: one alert pulse, flag set
// - Programmable duration; changing it restarts running timer
// - Doubling bit doubles fast timer under loops
// - Fallback to precharge restarts both timers
// - Supplement pauses timer without reset
// - Watchdog default on, started and kicked by host
// - Watchdog expiry restores control registers
package cpf_pkg;
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_MASK      = 4'h4;
	localparam logic [3:0]  REG_STATUS    = 4'h8;
	localparam logic [3:0]  REG_FLAG      = 4'hC;
	localparam int          CTRL_OVP_SEL  = 0;
	localparam int          CTRL_DEPL_LSB = 1;
	localparam int          CTRL_SAFE_LSB = 3;
	localparam int          CTRL_DOUBLE   = 5;
	localparam int          CTRL_WD_LSB   = 6;
	localparam logic [7:0]  CTRL_RESET    = 8'h48;
	localparam logic [3:0]  MASK_RESET    = 4'h0;
	localparam int          CLK_MHZ       = 100;
	localparam int          ALERT_US      = 128;
	localparam int          SH_OFF_US     = 200;
	localparam int          SH_ON_MS      = 5;
	localparam int          SH_LOCK_MS    = 2000;
	localparam int          HICCUP_MS     = 250;
	localparam int          OC_WIN_MS     = 2000;
	localparam int          ALERT_CYC     = ALERT_US * CLK_MHZ;
	localparam int          SH_OFF_CYC    = SH_OFF_US * CLK_MHZ;
	localparam int          SH_ON_CYC     = SH_ON_MS * 1000 * CLK_MHZ;
	localparam int          SH_LOCK_CYC   = SH_LOCK_MS * 1000 * CLK_MHZ;
	localparam int          HICCUP_CYC    = HICCUP_MS * 1000 * CLK_MHZ;
	localparam int          OC_WIN_CYC    = OC_WIN_MS * 1000 * CLK_MHZ;
	localparam int          SH_TRIES      = 10;
	localparam int          OC_TRIPS      = 4;
	localparam int          TICK_CYC      = 100000000;
	localparam int          SAFE_BASE     = 10800;
	localparam int          WD_BASE       = 20;
	typedef enum logic [1:0] {
		CPF_SH_IDLE = 2'b00,
		CPF_SH_OFF  = 2'b01,
		CPF_SH_ON   = 2'b10,
		CPF_SH_LOCK = 2'b11
	} cpf_short_t;
	typedef enum logic [1:0] {
		CPF_PH_IDLE = 2'b00,
		CPF_PH_PRE  = 2'b01,
		CPF_PH_CC   = 2'b10,
		CPF_PH_CV   = 2'b11
	} cpf_phase_t;
endpackage

//--- hw/cpf_fault_logic.sv
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module cpf_fault_logic
	import cpf_pkg::*;
#(
	parameter logic [31:0] ALERT_LEN  = ALERT_CYC,
	parameter logic [31:0] SH_OFF_LEN = SH_OFF_CYC,
	parameter logic [31:0] SH_ON_LEN  = SH_ON_CYC,
	parameter logic [31:0] SH_LCK_LEN = SH_LOCK_CYC,
	parameter logic [31:0] HICCUP_LEN = HICCUP_CYC,
	parameter logic [31:0] OC_WIN_LEN = OC_WIN_CYC,
	parameter logic [31:0] TICK_LEN   = TICK_CYC,
	parameter logic [31:0] SAFE_UNITS = SAFE_BASE,
	parameter logic [31:0] WD_UNITS   = WD_BASE
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        vin_above_ovp,
	input  wire logic        vin_below_ovp_release,
	input  wire logic        vin_above_uvlo,
	input  wire logic        vin_above_bat_hyst,
	input  wire logic        sys_below_short,
	input  wire logic        sys_above_release,
	input  wire logic        bat_above_depletion,
	input  wire logic        bat_above_lockout,
	input  wire logic        bat_overcurrent,
	input  wire logic        supplement_active,
	input  wire logic [1:0]  charge_phase,
	input  wire logic        other_loop_active,
	output logic             input_overvoltage_level_select,
	output logic [1:0]       battery_depletion_threshold,
	output logic             input_switch_on,
	output logic             battery_switch,
	output logic             input_power_valid,
	output logic             device_power_on,
	output logic             charge_disable,
	output logic             alert_n
);
	logic [7:0]  ctrl;
	logic [3:0]  mask;
	logic [3:0]  flags;
	cpf_short_t  sh_state;
	logic [31:0] sh_cnt;
	logic [3:0]  sh_tries;
	logic        ovp_live;
	logic        depl_q;
	logic        ocp_wait;
	logic        ocp_lock;
	logic [31:0] oc_cnt;
	logic [2:0]  oc_trips;
	logic        win_on;
	logic [31:0] win_cnt;
	logic        pg_q;
	logic [31:0] al_cnt;
	cpf_phase_t  ph_q;
	logic [31:0] st_cnt;
	logic [31:0] st_tick;
	logic        half;
	logic        wd_started;
	logic [31:0] wd_cnt;

	logic        bus_done;
	logic        ctrl_wr;
	logic        pg;
	logic        ovp_evt;
	logic        short_live;
	logic        sh_on_end;
	logic        short_evt;
	logic        depl_live;
	logic        depl_evt;
	logic        oc_trip;
	logic        fast;
	logic        slow;
	logic        st_restart;
	logic        st_step;
	logic [31:0] st_limit;
	logic        tmo_evt;
	logic        alert_req;
	logic [31:0] wd_period;
	logic        wd_fire;
	logic [3:0]  flag_set;
	logic [3:0]  flag_clr;

	assign bus_done   = (read | write) & ~waitrequest;
	assign ctrl_wr    = bus_done & write & byteenable[0] & (address == REG_CTRL);
	assign pg         = vin_above_uvlo & vin_above_bat_hyst & ~ovp_live;
	assign ovp_evt    = vin_above_ovp & ~ovp_live;
	assign short_live = (sh_state == CPF_SH_LOCK);
	assign sh_on_end  = (sh_state == CPF_SH_ON) & (sh_cnt == SH_ON_LEN - 32'h1);
	assign short_evt  = sh_on_end & ~sys_above_release & (sh_tries == 4'(SH_TRIES - 1));
	assign depl_live  = ~bat_above_depletion;
	assign depl_evt   = depl_live & ~depl_q;
	assign oc_trip    = bat_overcurrent & battery_switch;
	assign fast       = (charge_phase == CPF_PH_CC) | (charge_phase == CPF_PH_CV);
	assign slow       = ctrl[CTRL_DOUBLE] & fast & other_loop_active;
	assign st_limit   = fast ? (SAFE_UNITS << ctrl[CTRL_SAFE_LSB +: 2])
	                         : (SAFE_UNITS << ctrl[CTRL_SAFE_LSB +: 2]) >> 2;
	assign st_step    = ~supplement_active & ~charge_disable & (st_tick == TICK_LEN - 32'h1)
	                    & (~slow | half) & ~st_restart & (charge_phase != CPF_PH_IDLE);
	assign tmo_evt    = st_step & (st_cnt == st_limit - 32'h1);
	assign wd_period  = WD_UNITS << ctrl[CTRL_WD_LSB +: 2];
	assign wd_fire    = wd_started & (ctrl[CTRL_WD_LSB +: 2] != 2'h0) & ~bus_done
	                    & (wd_cnt == wd_period - 32'h1);
	assign flag_set   = {tmo_evt, depl_evt, short_evt, ovp_evt};
	assign flag_clr   = (bus_done & read & (address == REG_FLAG)) ? 4'hF : 4'h0;
	assign alert_req  = |(flag_set & ~mask);

	// Phase change restarts unless moving between the two fast phases
	always_comb begin
		st_restart = (cpf_phase_t'(charge_phase) != ph_q) & ~(fast & ((ph_q == CPF_PH_CC)
		             | (ph_q == CPF_PH_CV)));
		if (ctrl_wr && (writedata[CTRL_SAFE_LSB +: 2] != ctrl[CTRL_SAFE_LSB +: 2])
		    && charge_phase != CPF_PH_IDLE) begin
			st_restart = 1'b1;
		end
	end

	// Slave answers one cycle after a request is seen
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
			if (read && waitrequest) begin
				unique case (address)
					REG_CTRL:   readdata <= {24'h0, ctrl};
					REG_MASK:   readdata <= {28'h0, mask};
					REG_STATUS: readdata <= {26'h0, charge_disable, ocp_lock, depl_live,
					                         short_live, pg, ovp_live};
					REG_FLAG:   readdata <= {28'h0, flags};
					default:    readdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl <= CTRL_RESET;
			mask <= MASK_RESET;
		end else if (wd_fire) begin
			ctrl <= CTRL_RESET;
			mask <= MASK_RESET;
		end else if (bus_done && write && byteenable[0]) begin
			if (address == REG_CTRL)
				ctrl <= writedata[7:0];
			if (address == REG_MASK)
				mask <= writedata[3:0];
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			flags <= 4'h0;
		else
			flags <= flag_set | (flags & ~flag_clr);
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wd_started <= 1'b0;
			wd_cnt     <= 32'h0;
		end else if (bus_done) begin
			wd_started <= 1'b1;
			wd_cnt     <= 32'h0;
		end else if (wd_fire) begin
			wd_started <= 1'b0;
			wd_cnt     <= 32'h0;
		end else if (wd_started && ctrl[CTRL_WD_LSB +: 2] != 2'h0) begin
			wd_cnt <= wd_cnt + 32'h1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			ovp_live <= 1'b0;
		else if (vin_above_ovp)
			ovp_live <= 1'b1;
		else if (vin_below_ovp_release)
			ovp_live <= 1'b0;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sh_state <= CPF_SH_IDLE;
			sh_cnt   <= 32'h0;
			sh_tries <= 4'h0;
		end else if (!pg) begin
			sh_state <= CPF_SH_IDLE;
			sh_cnt   <= 32'h0;
			sh_tries <= 4'h0;
		end else begin
			unique case (sh_state)
				CPF_SH_IDLE: begin
					sh_cnt   <= 32'h0;
					sh_tries <= 4'h0;
					if (sys_below_short)
						sh_state <= CPF_SH_OFF;
				end
				CPF_SH_OFF: begin
					sh_cnt <= sh_cnt + 32'h1;
					if (sh_cnt == SH_OFF_LEN - 32'h1) begin
						sh_state <= CPF_SH_ON;
						sh_cnt   <= 32'h0;
					end
				end
				CPF_SH_ON: begin
					sh_cnt <= sh_cnt + 32'h1;
					if (sys_above_release) begin
						sh_state <= CPF_SH_IDLE;
					end else if (short_evt) begin
						sh_state <= CPF_SH_LOCK;
						sh_cnt   <= 32'h0;
						sh_tries <= 4'h0;
					end else if (sh_on_end) begin
						sh_state <= CPF_SH_OFF;
						sh_cnt   <= 32'h0;
						sh_tries <= sh_tries + 4'h1;
					end
				end
				CPF_SH_LOCK: begin
					sh_cnt <= sh_cnt + 32'h1;
					if (sh_cnt == SH_LCK_LEN - 32'h1) begin
						sh_state <= CPF_SH_ON;
						sh_cnt   <= 32'h0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ocp_wait <= 1'b0;
			ocp_lock <= 1'b0;
			oc_cnt   <= 32'h0;
			oc_trips <= 3'h0;
			win_on   <= 1'b0;
			win_cnt  <= 32'h0;
		end else begin
			if (ocp_wait) begin
				oc_cnt <= oc_cnt + 32'h1;
				if (oc_cnt == HICCUP_LEN - 32'h1)
					ocp_wait <= 1'b0;
			end
			if (win_on) begin
				win_cnt <= win_cnt + 32'h1;
				if (win_cnt == OC_WIN_LEN - 32'h1) begin
					win_on   <= 1'b0;
					oc_trips <= 3'h0;
				end
			end
			if (ocp_lock && pg && !pg_q) begin
				ocp_lock <= 1'b0;
				oc_trips <= 3'h0;
			end
			if (oc_trip) begin
				ocp_wait <= 1'b1;
				oc_cnt   <= 32'h0;
				oc_trips <= oc_trips + 3'h1;
				if ((supplement_active && pg) || oc_trips == 3'(OC_TRIPS - 1))
					ocp_lock <= 1'b1;
				if (!win_on) begin
					win_on  <= 1'b1;
					win_cnt <= 32'h0;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ph_q           <= CPF_PH_IDLE;
			st_cnt         <= 32'h0;
			st_tick        <= 32'h0;
			half           <= 1'b0;
			charge_disable <= 1'b0;
		end else begin
			ph_q <= cpf_phase_t'(charge_phase);
			if (charge_phase == CPF_PH_IDLE)
				charge_disable <= 1'b0;
			if (st_restart || charge_phase == CPF_PH_IDLE) begin
				st_cnt  <= 32'h0;
				st_tick <= 32'h0;
				half    <= 1'b0;
			end else if (!supplement_active && !charge_disable) begin
				st_tick <= st_tick + 32'h1;
				if (st_tick == TICK_LEN - 32'h1) begin
					st_tick <= 32'h0;
					half    <= ~half;
				end
				if (st_step)
					st_cnt <= st_cnt + 32'h1;
				if (tmo_evt)
					charge_disable <= 1'b1;
			end
		end
	end

	// A new alert event restarts the low pulse
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			al_cnt  <= 32'h0;
			alert_n <= 1'b1;
		end else begin
			if (alert_req)
				al_cnt <= ALERT_LEN;
			else if (al_cnt != 32'h0)
				al_cnt <= al_cnt - 32'h1;
			alert_n <= ~(alert_req | (al_cnt > 32'h1));
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pg_q                           <= 1'b0;
			depl_q                         <= 1'b0;
			input_power_valid              <= 1'b0;
			input_switch_on                <= 1'b0;
			battery_switch                 <= 1'b0;
			device_power_on                <= 1'b0;
			input_overvoltage_level_select <= 1'b0;
			battery_depletion_threshold    <= 2'h0;
		end else begin
			pg_q                           <= pg;
			depl_q                         <= depl_live;
			input_power_valid              <= pg;
			input_switch_on                <= pg & (sh_state != CPF_SH_OFF)
			                                  & (sh_state != CPF_SH_LOCK);
			battery_switch                 <= (vin_above_uvlo | bat_above_lockout)
			                                  & bat_above_depletion & ~ocp_wait
			                                  & ~ocp_lock;
			device_power_on                <= vin_above_uvlo | bat_above_lockout;
			input_overvoltage_level_select <= ctrl[CTRL_OVP_SEL];
			battery_depletion_threshold    <= ctrl[CTRL_DEPL_LSB +: 2];
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_ovp_input_off;
		$rose(ovp_live) |-> ##1 !input_switch_on && !input_power_valid;
	endproperty
	a_ovp_input_off: assert property (p_ovp_input_off) else $error("input on in overvoltage");

	property p_short_lock;
		short_evt |-> ##2 !input_switch_on && short_live && flags[1];
	endproperty
	a_short_lock: assert property (p_short_lock) else $error("short lockout missing");

	property p_depletion;
		!bat_above_depletion |-> ##1 !battery_switch;
	endproperty
	a_depletion: assert property (p_depletion) else $error("battery on below depletion");

	property p_ocp_off;
		oc_trip |-> ##1 ocp_wait ##1 !battery_switch;
	endproperty
	a_ocp_off: assert property (p_ocp_off) else $error("switch not opened on overcurrent");

	property p_power;
		!vin_above_uvlo && !bat_above_lockout |-> ##1 !device_power_on;
	endproperty
	a_power: assert property (p_power) else $error("powered below lockout");

	property p_timeout;
		tmo_evt |-> ##1 charge_disable && flags[3];
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not handled");

	property p_alert_pulse;
		$fell(alert_n) && !alert_req |-> !alert_n[*3];
	endproperty
	a_alert_pulse: assert property (p_alert_pulse) else $error("alert pulse too short");

	property p_flag_sticky;
		$fell(flags[0]) |-> $past(flag_clr[0]);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without read");

	property p_wd_restore;
		wd_fire |-> ##1 ctrl == CTRL_RESET && mask == MASK_RESET;
	endproperty
	a_wd_restore: assert property (p_wd_restore) else $error("watchdog restore failed");
endmodule // cpf_fault_logic

//--- verification/cpf_host_model.sv
`timescale 1ns/10ps
module cpf_host_model (
	input  wire logic        core_clk,
	output logic [3:0]       address,
	output logic             read,
	output logic             write,
	output logic [3:0]       byteenable,
	output logic [31:0]      writedata,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest
);
	initial begin
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'hF;
		writedata = 32'h0;
	end

	// Every access also restarts the device's host watchdog
	task automatic xfer(input logic is_wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		read <= !is_wr;
		write <= is_wr;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// Released data lines must not keep showing the last value
		writedata <= ~d;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, 4'hF, q);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, 4'hF, q);
	endtask

	// Write with chosen byte lanes; lane 0 off must leave registers alone
	task automatic wr_lanes(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		xfer(1'b1, a, d, be, q);
	endtask
endmodule // cpf_host_model

//--- verification/cpf_fault_logic_bench.sv
`timescale 1ns/10ps
module cpf_fault_logic_bench
	import cpf_pkg::*;
;
	logic        core_clk = 1'b0, reset = 1'b1;
	logic [3:0]  address, byteenable;
	logic        read, write, waitrequest;
	logic [31:0] writedata, readdata, q;
	logic        ovp = 1'b0, ovp_rel = 1'b1, uvlo = 1'b1, hyst = 1'b1;
	logic        short_n = 1'b0, sys_rel = 1'b1, depl = 1'b1, lockout = 1'b1;
	logic        oc = 1'b0, supp = 1'b0, other = 1'b0;
	logic [1:0]  phase = 2'h0;
	logic        sel, isw, bsw, pg, pwr, chg_dis, alert_n;
	logic [1:0]  thr;
	int          n_fail = 0, n_tests = 0, cyc = 0, t0;

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;

	cpf_host_model host (.core_clk(core_clk), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest));

	cpf_fault_logic #(.ALERT_LEN(8), .SH_OFF_LEN(4), .SH_ON_LEN(10), .SH_LCK_LEN(20),
		.HICCUP_LEN(10), .OC_WIN_LEN(100), .TICK_LEN(2), .SAFE_UNITS(8), .WD_UNITS(50)) dut (
		.core_clk(core_clk), .reset(reset), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .vin_above_ovp(ovp), .vin_below_ovp_release(ovp_rel),
		.vin_above_uvlo(uvlo), .vin_above_bat_hyst(hyst), .sys_below_short(short_n),
		.sys_above_release(sys_rel), .bat_above_depletion(depl), .bat_above_lockout(lockout),
		.bat_overcurrent(oc), .supplement_active(supp), .charge_phase(phase),
		.other_loop_active(other), .input_overvoltage_level_select(sel),
		.battery_depletion_threshold(thr), .input_switch_on(isw), .battery_switch(bsw),
		.input_power_valid(pg), .device_power_on(pwr), .charge_disable(chg_dis),
		.alert_n(alert_n));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic poll_status(input int b, input logic v);
		for (int i = 0; i < 120; i++) begin
			host.rd(REG_STATUS, q);
			if (q[b] === v) break;
		end
		tick(0);
	endtask

	task automatic wait_disable(output int d);
		t0 = cyc;
		for (int i = 0; i < 80 && chg_dis !== 1'b1; i++) tick(1);
		d = cyc - t0;
	endtask

	task automatic t_regs();
		host.rd(REG_CTRL, q);
		chk(q, 32'h48);
		host.rd(REG_MASK, q);
		chk(q, 32'h0);
		host.wr(4'h2, 32'hFF);
		host.rd(4'h2, q);
		chk(q, 32'h0);
		host.wr_lanes(REG_CTRL, 32'h00, 4'hE);
		host.rd(REG_CTRL, q);
		chk(q, 32'h48);
		$display("regs done");
	endtask

	task automatic t_ovp();
		@(posedge core_clk);
		ovp <= 1'b1;
		ovp_rel <= 1'b0;
		tick(3);
		chk(isw, 1'b0);
		chk(bsw, 1'b1);
		chk(pg, 1'b0);
		chk(alert_n, 1'b0);
		host.rd(REG_STATUS, q);
		chk(q[1:0], 2'h1);
		tick(12);
		chk(alert_n, 1'b1);
		ovp <= 1'b0;
		ovp_rel <= 1'b1;
		tick(3);
		chk({isw, pg}, 2'h3);
		host.rd(REG_STATUS, q);
		chk(q[1:0], 2'h2);
		host.rd(REG_FLAG, q);
		chk(q[0], 1'b1);
		host.rd(REG_FLAG, q);
		chk(q[0], 1'b0);
		hyst <= 1'b0;
		tick(3);
		chk(pg, 1'b0);
		hyst <= 1'b1;
		tick(3);
		chk(pg, 1'b1);
		$display("overvoltage done");
	endtask

	task automatic t_depl();
		@(posedge core_clk);
		uvlo <= 1'b0;
		depl <= 1'b0;
		tick(3);
		chk(bsw, 1'b0);
		chk(alert_n, 1'b0);
		chk(pwr, 1'b1);
		host.rd(REG_STATUS, q);
		chk(q[3], 1'b1);
		host.rd(REG_FLAG, q);
		chk(q[2], 1'b1);
		host.wr(REG_MASK, 32'h4);
		tick(12);
		depl <= 1'b1;
		tick(3);
		chk(bsw, 1'b1);
		depl <= 1'b0;
		tick(3);
		chk(bsw, 1'b0);
		chk(alert_n, 1'b1);
		lockout <= 1'b0;
		tick(3);
		chk(pwr, 1'b0);
		lockout <= 1'b1;
		depl <= 1'b1;
		uvlo <= 1'b1;
		host.wr(REG_MASK, 32'h0);
		host.rd(REG_FLAG, q);
		$display("depletion done");
	endtask

	task automatic t_short();
		@(posedge core_clk);
		short_n <= 1'b1;
		sys_rel <= 1'b0;
		t0 = cyc;
		tick(3);
		chk(isw, 1'b0);
		poll_status(2, 1'b1);
		chk((cyc - t0 >= 135) && (cyc - t0 <= 175), 1'b1);
		chk({q[2], isw, bsw}, 3'h5);
		host.rd(REG_FLAG, q);
		chk(q[1], 1'b1);
		poll_status(2, 1'b0);
		chk(q[2], 1'b0);
		tick(3);
		chk(isw, 1'b1);
		short_n <= 1'b0;
		sys_rel <= 1'b1;
		tick(30);
		chk(isw, 1'b1);
		$display("short done");
	endtask

	task automatic trip();
		@(posedge core_clk);
		oc <= 1'b1;
		@(posedge core_clk);
		oc <= 1'b0;
		tick(3);
		chk(bsw, 1'b0);
	endtask

	task automatic t_oc();
		trip();
		tick(12);
		chk(bsw, 1'b1);
		repeat (3) begin
			trip();
			tick(12);
		end
		tick(10);
		chk(bsw, 1'b0);
		host.rd(REG_STATUS, q);
		chk(q[4], 1'b1);
		uvlo <= 1'b0;
		tick(4);
		uvlo <= 1'b1;
		tick(4);
		host.rd(REG_STATUS, q);
		chk(q[4], 1'b0);
		supp <= 1'b1;
		trip();
		tick(30);
		chk(bsw, 1'b0);
		supp <= 1'b0;
		uvlo <= 1'b0;
		tick(4);
		uvlo <= 1'b1;
		tick(4);
		host.rd(REG_STATUS, q);
		chk(q[4], 1'b0);
		$display("overcurrent done");
	endtask

	task automatic t_timer();
		int d;
		@(posedge core_clk);
		phase <= 2'h1;
		tick(4);
		chk(chg_dis, 1'b0);
		wait_disable(d);
		chk(d <= 12, 1'b1);
		chk(alert_n, 1'b0);
		host.rd(REG_FLAG, q);
		chk(q[3], 1'b1);
		phase <= 2'h0;
		tick(3);
		chk(chg_dis, 1'b0);
		phase <= 2'h2;
		tick(1);
		wait_disable(d);
		chk((d >= 26) && (d <= 38), 1'b1);
		phase <= 2'h0;
		tick(3);
		phase <= 2'h2;
		tick(20);
		host.wr(REG_CTRL, 32'h50);
		tick(50);
		chk(chg_dis, 1'b0);
		phase <= 2'h0;
		host.wr(REG_CTRL, 32'h48);
		$display("safety timer done");
	endtask

	task automatic t_timer_modes();
		int d;
		host.wr(REG_CTRL, 32'h68);
		@(posedge core_clk);
		phase <= 2'h2;
		other <= 1'b1;
		tick(1);
		wait_disable(d);
		chk((d >= 58) && (d <= 70), 1'b1);
		phase <= 2'h0;
		other <= 1'b0;
		tick(3);
		phase <= 2'h2;
		tick(20);
		supp <= 1'b1;
		tick(60);
		chk(chg_dis, 1'b0);
		supp <= 1'b0;
		wait_disable(d);
		chk((d >= 10) && (d <= 16), 1'b1);
		phase <= 2'h0;
		tick(3);
		phase <= 2'h2;
		tick(20);
		phase <= 2'h1;
		tick(4);
		phase <= 2'h2;
		tick(1);
		wait_disable(d);
		chk((d >= 28) && (d <= 36), 1'b1);
		phase <= 2'h0;
		host.wr(REG_CTRL, 32'h48);
		$display("safety timer modes done");
	endtask

	task automatic t_wd();
		host.wr(REG_CTRL, 32'h4F);
		tick(60);
		chk({sel, thr}, 3'h7);
		host.rd(REG_CTRL, q);
		chk(q, 32'h4F);
		tick(150);
		chk({sel, thr}, 3'h0);
		host.rd(REG_CTRL, q);
		chk(q, 32'h48);
		$display("watchdog done");
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#200us;
		n_fail++;
		$display("Error at %0t: timeout seen %h expected %h", $time, 1'b0, 1'b1);
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		tick(2);
		t_regs();
		t_ovp();
		t_depl();
		t_short();
		t_oc();
		t_timer();
		t_timer_modes();
		t_wd();
		report_and_stop();
	end
endmodule // cpf_fault_logic_bench
